/* smbus_regport_pkg.sv */
// Summary of operation
// - Command byte: two zero MSBs, 6-bit index
// - Send byte only loads the pointer
// - Receive byte returns register at pointer
// - Write byte loads pointer then stores data
// - Read byte: command, repeated start, data
// - Writes advance pointer; past top discarded
// - Reads advance pointer; past top read zero
// - Alert driven low on request only
// - Alert response returns address, bit0 zero
// - Arbitrate address bits, lowest address wins
// - Host reads status after alert response
// - Status bits clear on read, re-set
// - Alert releases only when cause resolved
// - Defaults at reset; monitor waits start
// - No detections before first full cycle
// - Spin-up then duty one third
// - Software reset equals power-on reset
// - Reserved reads zero, writes ignored
// - Software writes bit7 of fourth config one; t_access writes 8'h00 to REG_TOP
// - Only four byte transactions supported
package smbus_regport_pkg;
    localparam logic [5:0] REG_PRI_CFG = 6'h00;
    localparam logic [5:0] REG_SEC_CFG = 6'h01;
    localparam logic [5:0] REG_STATUS_A = 6'h02;
    localparam logic [5:0] REG_STATUS_B = 6'h03;
    localparam logic [5:0] REG_TACH_CFG = 6'h04;
    localparam logic [5:0] REG_PART_ID = 6'h3d;
    localparam logic [5:0] REG_MAKER_ID = 6'h3e;
    localparam logic [5:0] REG_TOP = 6'h3f;
    localparam logic [7:0] RST_PRI_CFG = 8'hd4;
    localparam logic [7:0] RST_SEC_CFG = 8'h3d;
    localparam logic [7:0] RST_TACH_CFG = 8'h08;
    localparam logic [7:0] RST_THERM_CFG = 8'h82;
    localparam logic [7:0] THERM_CFG_RO_MASK = 8'h7f;
    localparam logic [7:0] TACH_CFG_RW_MASK = 8'hf0;
    localparam logic [7:0] TACH_CFG_FIXED = 8'h08;
    localparam int START_BIT = 0;
    localparam int GLOBAL_INT_BIT = 1;
    localparam int SOFT_RST_BIT = 7;
    localparam int MUST_ONE_BIT = 7;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
    localparam logic [7:0] DUTY_THIRD = 8'h55;
    localparam int SCL_HALF_CYCLES = 125;
    localparam int SPINUP_CYCLES = 50000;
    localparam int MONITOR_CYCLES = 5000;
    localparam logic [3:0] CMD_SEND = 4'h1;
    localparam logic [3:0] CMD_RECV = 4'h2;
    localparam logic [3:0] CMD_WRITE = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h4;
    localparam logic [3:0] CMD_ARA = 4'h5;
endpackage : smbus_regport_pkg

/* smbus_link_if.sv */
`timescale 1ns/100ps
interface smbus_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic sda_t;
    logic sda_t_oe;
    logic alert_oe;
    wire scl = !(scl_oe && !scl_o);
    wire sda = !((sda_oe && !sda_o) || (sda_t_oe && !sda_t));
    wire alert_n = !alert_oe;
    modport target (input scl, input sda, output sda_t, output sda_t_oe, output alert_oe);
    modport controller (output scl_o, output scl_oe, output sda_o, output sda_oe,
        input scl, input sda, input alert_n);
endinterface : smbus_link_if

/* smbus_target.sv */
`timescale 1ns/100ps
module smbus_target
    import smbus_regport_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h18,
    parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] MAKER_ID = 8'ha5, // Arbitrary value
    parameter int SPINUP = SPINUP_CYCLES,
    parameter int MONITOR = MONITOR_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Link
    smbus_link_if.target bus,
    // Monitoring side
    input wire logic [7:0] i_cause_a,
    input wire logic [7:0] i_cause_b,
    output logic o_monitoring,
    output logic o_detect_en,
    output logic [7:0] o_duty
);
    // Counters need at least one cycle to end spin-up and the first cycle
    if (SPINUP < 1 || MONITOR < 1) begin : g_bad_counts
        $error("Bad counts");
    end
    typedef enum {T_IDLE, T_ADDR, T_ACK, T_RX, T_TX, T_TXACK, T_SKIP} tstate_e;
    tstate_e st_r, st_nxt;
    logic scl_q_r, sda_q_r;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic rd_r, rd_nxt, ara_r, ara_nxt, have_cmd_r, have_cmd_nxt, ack_me_r, ack_me_nxt;
    logic [5:0] ptr_r, ptr_nxt;
    logic past_top_r, past_top_nxt;
    logic sda_t_r, sda_t_nxt, sda_oe_r, sda_oe_nxt;
    logic [7:0] pri_r, pri_nxt, sec_r, sec_nxt, tach_r, tach_nxt, therm_r, therm_nxt;
    logic [7:0] sta_r, sta_nxt, stb_r, stb_nxt;
    logic mon_r, mon_nxt, det_r, det_nxt, alert_r, alert_nxt;
    logic [7:0] duty_r, duty_nxt;
    logic [31:0] spin_r, spin_nxt, mcnt_r, mcnt_nxt;
    logic scl_rise, scl_fall, start_c, stop_c, soft_rst;

    function automatic logic [7:0] read_reg(input logic [5:0] a);
        unique case (a)
            REG_PRI_CFG: read_reg = pri_r;
            REG_SEC_CFG: read_reg = sec_r;
            REG_STATUS_A: read_reg = sta_r;
            REG_STATUS_B: read_reg = stb_r;
            REG_TACH_CFG: read_reg = tach_r;
            REG_PART_ID: read_reg = PART_ID;
            REG_MAKER_ID: read_reg = MAKER_ID;
            REG_TOP: read_reg = therm_r;
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    assign scl_rise = bus.scl && !scl_q_r;
    assign scl_fall = !bus.scl && scl_q_r;
    assign start_c = bus.scl && scl_q_r && sda_q_r && !bus.sda;
    assign stop_c = bus.scl && scl_q_r && !sda_q_r && bus.sda;

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        ara_nxt = ara_r;
        have_cmd_nxt = have_cmd_r;
        ack_me_nxt = ack_me_r;
        ptr_nxt = ptr_r;
        past_top_nxt = past_top_r;
        sda_t_nxt = sda_t_r;
        sda_oe_nxt = sda_oe_r;
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        tach_nxt = tach_r;
        therm_nxt = therm_r;
        sta_nxt = sta_r;
        stb_nxt = stb_r;
        soft_rst = 1'b0;
        if (start_c) begin
            st_nxt = T_ADDR;
            bit_nxt = 4'd0;
            have_cmd_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = T_IDLE;
            sda_oe_nxt = 1'b0;
            past_top_nxt = 1'b0;
        end else begin
            unique case (st_r)
                T_IDLE, T_SKIP: begin
                    sda_oe_nxt = 1'b0;
                end
                T_ADDR, T_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], bus.sda};
                        bit_nxt = bit_r + 4'd1;
                    end
                    if (scl_fall && bit_r == 4'd8) begin
                        bit_nxt = 4'd0;
                        st_nxt = T_ACK;
                        sda_t_nxt = 1'b0;
                        sda_oe_nxt = 1'b1;
                        ack_me_nxt = 1'b0;
                        if (st_r == T_ADDR) begin
                            rd_nxt = sh_r[0];
                            ara_nxt = sh_r[7:1] == ALERT_RESP_ADDR && sh_r[0] && alert_r;
                            if (sh_r[7:1] == TARGET_ADDR || ara_nxt) begin
                                ack_me_nxt = 1'b1;
                            end else begin
                                sda_oe_nxt = 1'b0;
                                st_nxt = T_SKIP;
                            end
                        end else if (!have_cmd_r) begin
                            ptr_nxt = sh_r[5:0];
                            have_cmd_nxt = 1'b1;
                            past_top_nxt = 1'b0;
                        end else if (!past_top_r) begin
                            unique case (ptr_r)
                                REG_PRI_CFG: pri_nxt = sh_r;
                                REG_SEC_CFG: begin
                                    sec_nxt = sh_r;
                                    soft_rst = sh_r[SOFT_RST_BIT];
                                end
                                REG_TACH_CFG: tach_nxt = (sh_r & TACH_CFG_RW_MASK)
                                    | TACH_CFG_FIXED;
                                REG_TOP: therm_nxt = (sh_r & ~THERM_CFG_RO_MASK)
                                    | (therm_r & THERM_CFG_RO_MASK);
                                default: ;
                            endcase
                            if (ptr_r == REG_TOP) past_top_nxt = 1'b1;
                            else ptr_nxt = ptr_r + 6'd1;
                        end
                    end
                end
                T_ACK: begin
                    if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        if (rd_r) begin
                            st_nxt = T_TX;
                            sh_nxt = ara_r ? {TARGET_ADDR, 1'b0}
                                : past_top_r ? 8'h00 : read_reg(ptr_r);
                            if (!ara_r) begin
                                if (ptr_r == REG_STATUS_A) sta_nxt = 8'h00;
                                if (ptr_r == REG_STATUS_B) stb_nxt = 8'h00;
                                if (ptr_r == REG_TOP) past_top_nxt = 1'b1;
                                else if (!past_top_r) ptr_nxt = ptr_r + 6'd1;
                            end
                            sda_t_nxt = sh_nxt[7];
                            sda_oe_nxt = 1'b1;
                            bit_nxt = 4'd0;
                        end else begin
                            st_nxt = T_RX;
                        end
                    end
                end
                T_TX: begin
                    if (scl_rise && sda_oe_r && sda_t_r && !bus.sda) begin
                        sda_oe_nxt = 1'b0;
                        st_nxt = T_SKIP;
                    end else if (scl_fall) begin
                        bit_nxt = bit_r + 4'd1;
                        sh_nxt = {sh_r[6:0], 1'b0};
                        sda_t_nxt = sh_r[6];
                        if (bit_r == 4'd7) begin
                            sda_oe_nxt = 1'b0;
                            st_nxt = T_TXACK;
                        end
                    end
                end
                T_TXACK: begin
                    if (scl_rise) begin
                        if (bus.sda || ara_r) st_nxt = T_SKIP;
                        else st_nxt = T_ACK;
                    end
                end
                default: st_nxt = T_IDLE;
            endcase
        end
        if (det_r) begin
            sta_nxt = sta_nxt | i_cause_a;
            stb_nxt = stb_nxt | i_cause_b;
        end
    end

    always_comb begin
        mon_nxt = pri_r[START_BIT];
        spin_nxt = spin_r;
        duty_nxt = duty_r;
        mcnt_nxt = mcnt_r;
        det_nxt = det_r;
        if (spin_r != 0) begin
            spin_nxt = spin_r - 32'd1;
            duty_nxt = 8'hff;
        end else begin
            duty_nxt = DUTY_THIRD;
        end
        if (!mon_r) begin
            mcnt_nxt = 32'd0;
        end else if (!det_r) begin
            if (mcnt_r == 32'(MONITOR - 1)) det_nxt = 1'b1;
            else mcnt_nxt = mcnt_r + 32'd1;
        end
        alert_nxt = det_r && pri_r[GLOBAL_INT_BIT] && ((i_cause_a | i_cause_b) != 8'h00);
    end

    always_ff @(posedge i_mclk) begin
        scl_q_r <= bus.scl;
        sda_q_r <= bus.sda;
        if (i_sys_rst || soft_rst) begin
            st_r <= T_IDLE;
            bit_r <= 4'd0;
            sh_r <= 8'h00;
            rd_r <= 1'b0;
            ara_r <= 1'b0;
            have_cmd_r <= 1'b0;
            ack_me_r <= 1'b0;
            ptr_r <= 6'd0;
            past_top_r <= 1'b0;
            sda_t_r <= 1'b1;
            sda_oe_r <= 1'b0;
            pri_r <= RST_PRI_CFG;
            sec_r <= RST_SEC_CFG & 8'h7f;
            tach_r <= RST_TACH_CFG;
            therm_r <= RST_THERM_CFG;
            sta_r <= 8'h00;
            stb_r <= 8'h00;
            mon_r <= 1'b0;
            det_r <= 1'b0;
            alert_r <= 1'b0;
            duty_r <= 8'hff;
            spin_r <= 32'(SPINUP);
            mcnt_r <= 32'd0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            ara_r <= ara_nxt;
            have_cmd_r <= have_cmd_nxt;
            ack_me_r <= ack_me_nxt;
            ptr_r <= ptr_nxt;
            past_top_r <= past_top_nxt;
            sda_t_r <= sda_t_nxt;
            sda_oe_r <= sda_oe_nxt;
            pri_r <= pri_nxt;
            sec_r <= sec_nxt;
            tach_r <= tach_nxt;
            therm_r <= therm_nxt;
            sta_r <= sta_nxt;
            stb_r <= stb_nxt;
            mon_r <= mon_nxt;
            det_r <= det_nxt;
            alert_r <= alert_nxt;
            duty_r <= duty_nxt;
            spin_r <= spin_nxt;
            mcnt_r <= mcnt_nxt;
        end
    end

    assign bus.sda_t = sda_t_r;
    assign bus.sda_t_oe = sda_oe_r;
    assign bus.alert_oe = alert_r;
    assign o_monitoring = mon_r;
    assign o_detect_en = det_r;
    assign o_duty = duty_r;
endmodule : smbus_target

/* smbus_controller.sv */
`timescale 1ns/100ps
module smbus_controller
    import smbus_regport_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h18,
    parameter int HALF = SCL_HALF_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Link
    smbus_link_if.controller bus,
    // Command port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata
);
    // Divider is 16 bits wide
    if (HALF < 2 || HALF > 65536) begin : g_bad_half
        $error("Bad half period");
    end
    // Port map: 0 cmd(write starts), 1 index, 2 data/result, 3 status
    typedef enum {C_IDLE, C_START, C_BYTE, C_ACK, C_RSTART, C_STOP} cstate_e;
    cstate_e st_r, st_nxt;
    logic [15:0] div_r, div_nxt;
    logic ph_r, ph_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [7:0] idx_r, idx_nxt, dat_r, dat_nxt, res_r, res_nxt, sh_r, sh_nxt, rdata_r, rdata_nxt;
    logic [2:0] step_r, step_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic nack_r, nack_nxt, busy_r, busy_nxt;
    logic scl_r, scl_nxt, sda_r, sda_nxt;
    logic tick, rx;

    function automatic logic [7:0] frame_byte(input logic [2:0] s, input logic [3:0] c);
        unique case (s)
            3'd0: frame_byte = {(c == CMD_ARA) ? ALERT_RESP_ADDR : TARGET_ADDR,
                c == CMD_RECV || c == CMD_ARA};
            3'd1: frame_byte = {2'b00, idx_r[5:0]};
            3'd3: frame_byte = {TARGET_ADDR, 1'b1};
            default: frame_byte = dat_r;
        endcase
    endfunction : frame_byte

    assign tick = div_r == 16'(HALF - 1);
    assign rx = (step_r == 3'd4);

    always_comb begin
        st_nxt = st_r;
        div_nxt = tick ? 16'd0 : div_r + 16'd1;
        ph_nxt = ph_r;
        cmd_nxt = cmd_r;
        idx_nxt = idx_r;
        dat_nxt = dat_r;
        res_nxt = res_r;
        sh_nxt = sh_r;
        step_nxt = step_r;
        bit_nxt = bit_r;
        nack_nxt = nack_r;
        busy_nxt = busy_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        rdata_nxt = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                2'd0: rdata_nxt = {4'h0, cmd_r};
                2'd1: rdata_nxt = idx_r;
                2'd2: rdata_nxt = res_r;
                2'd3: rdata_nxt = {5'h00, !bus.alert_n, nack_r, busy_r};
            endcase
        end
        if (i_wr && !busy_r) begin
            if (i_addr == 2'd1) idx_nxt = i_wdata;
            if (i_addr == 2'd2) dat_nxt = i_wdata;
            if (i_addr == 2'd0) begin
                cmd_nxt = i_wdata[3:0];
                busy_nxt = 1'b1;
                nack_nxt = 1'b0;
                st_nxt = C_START;
                div_nxt = 16'd0;
                ph_nxt = 1'b0;
            end
        end else if (tick) begin
            ph_nxt = !ph_r;
            unique case (st_r)
                C_IDLE: begin
                    scl_nxt = 1'b1;
                    sda_nxt = 1'b1;
                end
                C_START: begin
                    if (!ph_r) sda_nxt = 1'b0;
                    else begin
                        scl_nxt = 1'b0;
                        st_nxt = C_BYTE;
                        step_nxt = 3'd0;
                        bit_nxt = 4'd0;
                        sh_nxt = frame_byte(3'd0, cmd_r);
                    end
                end
                C_BYTE: begin
                    if (!ph_r) begin
                        sda_nxt = rx ? 1'b1 : sh_r[7];
                    end else if (!scl_r) begin
                        scl_nxt = 1'b1;
                        ph_nxt = ph_r;
                    end else begin
                        scl_nxt = 1'b0;
                        sh_nxt = {sh_r[6:0], bus.sda};
                        bit_nxt = bit_r + 4'd1;
                        if (bit_r == 4'd7) st_nxt = C_ACK;
                    end
                end
                C_ACK: begin
                    if (!ph_r) begin
                        sda_nxt = rx ? 1'b1 : 1'b1; // NACK ends each single-byte read
                    end else if (!scl_r) begin
                        scl_nxt = 1'b1;
                        ph_nxt = ph_r;
                        if (!rx && bus.sda) nack_nxt = 1'b1;
                    end else begin
                        scl_nxt = 1'b0;
                        bit_nxt = 4'd0;
                        if (rx) res_nxt = sh_r;
                        if (nack_r || rx) st_nxt = C_STOP;
                        else if (step_r == 3'd0 && (cmd_r == CMD_RECV || cmd_r == CMD_ARA)) begin
                            step_nxt = 3'd4;
                            st_nxt = C_BYTE;
                        end else if (step_r == 3'd0) begin
                            step_nxt = 3'd1;
                            sh_nxt = frame_byte(3'd1, cmd_r);
                            st_nxt = C_BYTE;
                        end else if (step_r == 3'd1 && cmd_r == CMD_WRITE) begin
                            step_nxt = 3'd2;
                            sh_nxt = frame_byte(3'd2, cmd_r);
                            st_nxt = C_BYTE;
                        end else if (step_r == 3'd1 && cmd_r == CMD_READ) begin
                            st_nxt = C_RSTART;
                        end else if (step_r == 3'd3) begin
                            step_nxt = 3'd4;
                            st_nxt = C_BYTE;
                        end else st_nxt = C_STOP;
                    end
                end
                C_RSTART: begin
                    if (!ph_r) sda_nxt = 1'b1;
                    else if (!scl_r) begin
                        scl_nxt = 1'b1;
                        ph_nxt = ph_r;
                    end else begin
                        sda_nxt = 1'b0;
                        st_nxt = C_START;
                        cmd_nxt = CMD_RECV;
                    end
                end
                C_STOP: begin
                    if (!ph_r) sda_nxt = 1'b0;
                    else if (!scl_r) begin
                        scl_nxt = 1'b1;
                        ph_nxt = ph_r;
                    end else begin
                        sda_nxt = 1'b1;
                        busy_nxt = 1'b0;
                        st_nxt = C_IDLE;
                    end
                end
                default: st_nxt = C_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_r <= C_IDLE;
            div_r <= 16'd0;
            ph_r <= 1'b0;
            cmd_r <= 4'h0;
            idx_r <= 8'h00;
            dat_r <= 8'h00;
            res_r <= 8'h00;
            sh_r <= 8'h00;
            step_r <= 3'd0;
            bit_r <= 4'd0;
            nack_r <= 1'b0;
            busy_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            ph_r <= ph_nxt;
            cmd_r <= cmd_nxt;
            idx_r <= idx_nxt;
            dat_r <= dat_nxt;
            res_r <= res_nxt;
            sh_r <= sh_nxt;
            step_r <= step_nxt;
            bit_r <= bit_nxt;
            nack_r <= nack_nxt;
            busy_r <= busy_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_r;
    assign bus.sda_o = 1'b0;
    assign bus.sda_oe = !sda_r;
    assign o_rdata = rdata_r;
endmodule : smbus_controller

/* smbus_regport_assertions.sv */
`timescale 1ns/100ps
module smbus_regport_assertions (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_t_oe,
    input wire logic alert_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $rose(sda);
    endsequence
    a_reset_idle: assert property ($fell(i_sys_rst) |-> !sda_t_oe && scl && sda)
        else $error("bus busy after reset");
    a_alert_quiet: assert property ($fell(i_sys_rst) |-> !alert_oe [*8])
        else $error("alert right after reset");
    a_drive_on_low: assert property ($changed(sda_t_oe) |-> !scl)
        else $error("target drive changed with clock high");
    a_drive_held: assert property (sda_t_oe && $rose(scl) |=> sda_t_oe)
        else $error("target drive dropped in high phase");
    a_addr_quiet: assert property (start_s |-> !sda_t_oe [*8])
        else $error("target drives during address");
    a_stop_quiet: assert property (stop_s |=> !sda_t_oe [*4])
        else $error("target drives after stop");
    // Ack plus eight data bits take 108 cycles at a four-cycle half period
    a_drive_bounded: assert property ($rose(sda_t_oe) |-> ##[1:200] !sda_t_oe)
        else $error("target drive never released");
    a_data_stable: assert property ($rose(scl) |=> $stable(sda))
        else $error("data moved in high phase");
endmodule : smbus_regport_assertions

/* test_smbus_register_port_with_alert.sv */
`timescale 1ns/100ps
module test_smbus_register_port_with_alert;
    import smbus_regport_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_cause_a = 8'h00;
    logic [7:0] o_rdata;
    logic [7:0] o_duty;
    logic o_monitoring;
    logic o_detect_en;
    logic [7:0] r;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    smbus_link_if bus ();
    smbus_target #(.SPINUP(20), .MONITOR(10)) u_smbus_target (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .bus(bus), .i_cause_a(i_cause_a), .i_cause_b(8'h00),
        .o_monitoring(o_monitoring), .o_detect_en(o_detect_en), .o_duty(o_duty));
    smbus_controller #(.HALF(4)) u_smbus_controller (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .bus(bus), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata));
    smbus_regport_assertions u_smbus_regport_assertions (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .scl(bus.scl), .sda(bus.sda), .sda_t_oe(bus.sda_t_oe),
        .alert_oe(bus.alert_oe));
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    // Edge first, so a lowered strobe is never raised in the same step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd
    task automatic xfer(input logic [3:0] c, input logic [5:0] x, input logic [7:0] d);
        logic [7:0] s;
        wr(2'h1, {2'b00, x});
        wr(2'h2, d);
        wr(2'h0, {4'h0, c});
        s = 8'h01;
        for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) begin
            rd(2'h3, s);
        end
        chk({7'h00, s[0]}, 8'h00);
        rd(2'h2, r);
    endtask : xfer
    task automatic t_defaults;
        chk(o_duty, 8'hff);
        xfer(CMD_READ, REG_PRI_CFG, 8'h00);
        chk(r, 8'hd4);
        xfer(CMD_READ, REG_SEC_CFG, 8'h00);
        chk(r, 8'h3d);
        xfer(CMD_READ, REG_TACH_CFG, 8'h00);
        chk(r, 8'h08);
        xfer(CMD_READ, REG_TOP, 8'h00);
        chk(r, 8'h82);
        chk(o_duty, 8'h55);
        chk({7'h00, o_detect_en}, 8'h00);
    endtask : t_defaults
    task automatic t_access;
        xfer(CMD_WRITE, REG_TACH_CFG, 8'ha5);
        xfer(CMD_READ, REG_TACH_CFG, 8'h00);
        chk(r, 8'ha8);
        xfer(CMD_WRITE, REG_TOP, 8'h00);
        xfer(CMD_READ, REG_TOP, 8'h00);
        chk(r, 8'h02);
        xfer(CMD_SEND, REG_TACH_CFG, 8'hff);
        xfer(CMD_RECV, 6'h00, 8'h00);
        chk(r, 8'ha8);
        xfer(CMD_WRITE, 6'h05, 8'hff);
        xfer(CMD_READ, 6'h05, 8'h00);
        chk(r, 8'h00);
    endtask : t_access
    task automatic t_alert;
        @(posedge i_mclk);
        i_cause_a <= 8'h01;
        repeat (20) @(posedge i_mclk);
        chk({7'h00, bus.alert_n}, 8'h01);
        xfer(CMD_WRITE, REG_PRI_CFG, 8'hd7);
        chk({7'h00, o_monitoring}, 8'h01);
        chk({7'h00, o_detect_en}, 8'h01);
        chk({7'h00, bus.alert_n}, 8'h00);
        xfer(CMD_ARA, 6'h00, 8'h00);
        chk(r, 8'h30);
        xfer(CMD_READ, REG_STATUS_A, 8'h00);
        chk(r, 8'h01);
        chk({7'h00, bus.alert_n}, 8'h00);
        @(posedge i_mclk);
        i_cause_a <= 8'h00;
        // Cause was still present after the first read, so the bit was set again
        xfer(CMD_READ, REG_STATUS_A, 8'h00);
        chk(r, 8'h01);
        xfer(CMD_READ, REG_STATUS_A, 8'h00);
        chk(r, 8'h00);
        chk({7'h00, bus.alert_n}, 8'h01);
    endtask : t_alert
    task automatic t_soft_reset;
        xfer(CMD_WRITE, REG_SEC_CFG, 8'hbd);
        chk({7'h00, o_monitoring}, 8'h00);
        xfer(CMD_READ, REG_PRI_CFG, 8'h00);
        chk(r, 8'hd4);
    endtask : t_soft_reset
    task automatic complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // Whole run is 19 transfers of a few hundred cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        t_defaults();
        t_access();
        t_alert();
        t_soft_reset();
        complete_run();
    end
endmodule : test_smbus_register_port_with_alert
